// File: core/tpw_pkg.sv
// package: register map, field positions and reset values of the timer/pwm block
package tpw_pkg;
    // register offsets on the plain register port
    localparam logic [1:0] ADDR_CONTROL = 2'h0;
    localparam logic [1:0] ADDR_BOUND = 2'h1;
    localparam logic [1:0] ADDR_SCALING = 2'h2;
    localparam logic [1:0] ADDR_COUNT = 2'h3;
    // reset values
    localparam logic [7:0] CONTROL_RST = 8'h00;
    localparam logic [7:0] BOUND_RST = 8'h00;
    localparam logic [7:0] SCALING_RST = 8'h00;
    // control register fields
    localparam int CTL_SRC_HI = 7;
    localparam int CTL_SRC_LO = 4;
    localparam int CTL_PIN_HI = 3;
    localparam int CTL_PIN_LO = 2;
    localparam int CTL_PWM_BIT = 1;
    // scaling register fields
    localparam int SCL_SIX_BIT = 7;
    localparam int SCL_PRE_HI = 6;
    localparam int SCL_PRE_LO = 5;
    localparam int SCL_DIV_HI = 4;
    // clock source codes
    localparam logic [3:0] SRC_STOP = 4'h0;
    localparam logic [3:0] SRC_SYSCLK = 4'h1;
    // pin routing codes
    localparam logic [1:0] PIN_NONE = 2'h0;
    localparam logic [1:0] PIN_A = 2'h1;
    localparam logic [1:0] PIN_B = 2'h2;
    localparam logic [1:0] PIN_C = 2'h3;
    // pwm resolution maxima
    localparam logic [7:0] MAX_8BIT = 8'hFF;
    localparam logic [7:0] MAX_6BIT = 8'h3F;
    // pre-scale terminal counts for /1 /4 /16 /64
    localparam logic [5:0] PRE_TC_1 = 6'h00;
    localparam logic [5:0] PRE_TC_4 = 6'h03;
    localparam logic [5:0] PRE_TC_16 = 6'h0F;
    localparam logic [5:0] PRE_TC_64 = 6'h3F;
    // operating modes
    typedef enum logic [1:0] {
        TPW_PERIOD,
        TPW_PWM8,
        TPW_PWM6
    } tpw_mode_e;
endpackage

// File: core/tpw_clk_div.sv
// divider chain: source select, pre-scaler and scaler, giving a tick enable
`timescale 1ns/1ps
module tpw_clk_div (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // configuration
    input wire logic [3:0] src_sel,
    input wire logic [1:0] pre_sel,
    input wire logic [4:0] scaler,
    // external source enables, one pulse per source edge
    input wire logic [14:0] ext_src_en,
    // divided tick
    output logic tick
);
    logic [5:0] pre_q;
    logic [5:0] pre_d;
    logic [4:0] scl_q;
    logic [4:0] scl_d;
    logic [5:0] pre_tc;
    logic src_en;
    logic pre_wrap;

    // source 0 stops the timer, 1 is the system clock, others are external pulses
    assign src_en = (src_sel == tpw_pkg::SRC_STOP) ? 1'b0 :
                    (src_sel == tpw_pkg::SRC_SYSCLK) ? 1'b1 :
                    ext_src_en[src_sel - 4'h1];

    // pre-scale factor in code order 1, 4, 16, 64
    assign pre_tc = (pre_sel == 2'h0) ? tpw_pkg::PRE_TC_1 :
                    (pre_sel == 2'h1) ? tpw_pkg::PRE_TC_4 :
                    (pre_sel == 2'h2) ? tpw_pkg::PRE_TC_16 :
                    tpw_pkg::PRE_TC_64;
    assign pre_wrap = src_en && (pre_q >= pre_tc);
    assign pre_d = !src_en ? pre_q : (pre_wrap ? 6'h00 : pre_q + 6'h01);
    // scaler divides by value plus one; >= guards a shrinking setting
    assign scl_d = !pre_wrap ? scl_q : ((scl_q >= scaler) ? 5'h00 : scl_q + 5'h01);
    assign tick = pre_wrap && (scl_q >= scaler);

    // both counters advance only on enabled source edges
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pre_q <= 6'h00;
            scl_q <= 5'h00;
        end else begin
            pre_q <= pre_d;
            scl_q <= scl_d;
        end
    end
endmodule

// File: core/tpw_timer.sv
// 8-bit up-counting timer with period and pwm modes, and a plain register port
//
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/1ps
// Summary of operation
// - period mode gives 50% square wave at Y/(2(K+1)S1(S2+1)).
// - control bits 7:4 pick the timer clock; 0001 is the system clock.
// - the whole 8-bit bound register is the count limit K.
// - scaling bits 6:5 pick pre-scale 1, 4, 16 or 64.
// - scaling bits 4:0 divide further by value plus one.
// - control bit 1 set with scaling bit 7 clear selects 8-bit pwm.
// - 8-bit pwm period is 256 ticks, high for K+1 of them.
// - bound at resolution maximum holds the output high.
// - control bit 1 set with scaling bit 7 set selects 6-bit pwm, 64 ticks, duty (K+1)/64.
// - counter counts up, clears at bound in period mode, readable and writable by software.
// - control bits 3:2 route output to one of three pins, forcing it.
// - with comparator gating, output is off while comparator reads one.
module tpw_timer #(
    parameter bit COMPARATOR_GATING_OPTION = 1'b0
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // register port
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // clock sources other than the system clock, one-cycle enables
    input wire logic [14:0] ext_src_en,
    // comparator result
    input wire logic cmp_result,
    // pins: output value and enable for each routable pin
    output logic output_pin_a,
    output logic output_pin_a_oe,
    output logic output_pin_b,
    output logic output_pin_b_oe,
    output logic output_pin_c,
    output logic output_pin_c_oe,
    // comparator-gated waveform, for observation
    output logic wave_out
);
    logic [7:0] timer_control_q;
    logic [7:0] timer_bound_q;
    logic [7:0] timer_scaling_q;
    logic [7:0] count_q;
    logic [7:0] count_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic wave_q;
    logic wave_d;
    logic tick;
    logic wr_ctl;
    logic wr_bnd;
    logic wr_scl;
    logic wr_cnt;
    logic [7:0] res_max;
    logic at_bound;
    logic at_res_end;
    logic gated_wave;
    logic [1:0] pin_sel;
    tpw_pkg::tpw_mode_e mode;

    // divider chain
    tpw_clk_div u_div (
        .clk(clk),
        .nrst(nrst),
        .src_sel(timer_control_q[tpw_pkg::CTL_SRC_HI:tpw_pkg::CTL_SRC_LO]),
        .pre_sel(timer_scaling_q[tpw_pkg::SCL_PRE_HI:tpw_pkg::SCL_PRE_LO]),
        .scaler(timer_scaling_q[tpw_pkg::SCL_DIV_HI:0]),
        .ext_src_en(ext_src_en),
        .tick(tick)
    );

    // register write decode
    assign wr_ctl = reg_wr && (reg_addr == tpw_pkg::ADDR_CONTROL);
    assign wr_bnd = reg_wr && (reg_addr == tpw_pkg::ADDR_BOUND);
    assign wr_scl = reg_wr && (reg_addr == tpw_pkg::ADDR_SCALING);
    assign wr_cnt = reg_wr && (reg_addr == tpw_pkg::ADDR_COUNT);

    // mode decode: bit 7 of scaling picks 6-bit only when pwm is on
    assign mode = !timer_control_q[tpw_pkg::CTL_PWM_BIT] ? tpw_pkg::TPW_PERIOD :
                  timer_scaling_q[tpw_pkg::SCL_SIX_BIT] ? tpw_pkg::TPW_PWM6 :
                  tpw_pkg::TPW_PWM8;
    assign res_max = (mode == tpw_pkg::TPW_PWM6) ? tpw_pkg::MAX_6BIT : tpw_pkg::MAX_8BIT;

    // wrap points; >= keeps the counter bounded if software shrinks the limit
    assign at_bound = (count_q >= timer_bound_q);
    assign at_res_end = (count_q >= res_max);

    // counter next value; a software write wins over a tick
    always_comb begin
        count_d = count_q;
        if (wr_cnt) begin
            count_d = reg_wdata;
        end else if (tick) begin
            case (mode)
                tpw_pkg::TPW_PERIOD: count_d = at_bound ? 8'h00 : count_q + 8'h01;
                tpw_pkg::TPW_PWM8,
                tpw_pkg::TPW_PWM6: count_d = at_res_end ? 8'h00 : count_q + 8'h01;
                default: count_d = 8'h00;
            endcase
        end
    end

    // waveform next value
    always_comb begin
        wave_d = wave_q;
        case (mode)
            tpw_pkg::TPW_PERIOD: begin
                if (tick && at_bound && !wr_cnt) begin
                    wave_d = !wave_q;
                end
            end
            tpw_pkg::TPW_PWM8,
            tpw_pkg::TPW_PWM6: begin
                if (timer_bound_q >= res_max) begin
                    wave_d = 1'b1;
                end else begin
                    wave_d = (count_d <= timer_bound_q);
                end
            end
            default: wave_d = 1'b0;
        endcase
    end

    // comparator gating holds the output low while the comparator reads one
    assign gated_wave = (COMPARATOR_GATING_OPTION && cmp_result) ? 1'b0 : wave_q;
    assign wave_out = gated_wave;

    // pin routing forces the selected pin to drive the waveform
    assign pin_sel = timer_control_q[tpw_pkg::CTL_PIN_HI:tpw_pkg::CTL_PIN_LO];
    assign output_pin_a_oe = (pin_sel == tpw_pkg::PIN_A);
    assign output_pin_b_oe = (pin_sel == tpw_pkg::PIN_B);
    assign output_pin_c_oe = (pin_sel == tpw_pkg::PIN_C);
    assign output_pin_a = output_pin_a_oe && gated_wave;
    assign output_pin_b = output_pin_b_oe && gated_wave;
    assign output_pin_c = output_pin_c_oe && gated_wave;

    // read mux, data lands one cycle after the strobe
    assign rdata_d = !reg_rd ? 8'h00 :
                     (reg_addr == tpw_pkg::ADDR_CONTROL) ? timer_control_q :
                     (reg_addr == tpw_pkg::ADDR_BOUND) ? timer_bound_q :
                     (reg_addr == tpw_pkg::ADDR_SCALING) ? timer_scaling_q :
                     count_q;
    assign reg_rdata = rdata_q;

    // configuration registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            timer_control_q <= tpw_pkg::CONTROL_RST;
            timer_bound_q <= tpw_pkg::BOUND_RST;
            timer_scaling_q <= tpw_pkg::SCALING_RST;
        end else begin
            if (wr_ctl) timer_control_q <= reg_wdata;
            if (wr_bnd) timer_bound_q <= reg_wdata;
            if (wr_scl) timer_scaling_q <= reg_wdata;
        end
    end

    // counter, waveform and read data
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            count_q <= 8'h00;
            wave_q <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            count_q <= count_d;
            wave_q <= wave_d;
            rdata_q <= rdata_d;
        end
    end

    // checks
    a_count_wraps_bound: assert property (@(posedge clk) disable iff (!nrst)
        (mode == tpw_pkg::TPW_PERIOD && tick && !wr_cnt && at_bound) |=> count_q == 8'h00)
        else $error("period counter did not clear at bound");
    a_period_toggle: assert property (@(posedge clk) disable iff (!nrst)
        (mode == tpw_pkg::TPW_PERIOD && tick && !wr_cnt && at_bound) |=> wave_q != $past(wave_q))
        else $error("period output did not toggle at wrap");
    a_period_hold: assert property (@(posedge clk) disable iff (!nrst)
        (mode == tpw_pkg::TPW_PERIOD && !(tick && at_bound)) |=> $stable(wave_q))
        else $error("period output changed away from wrap");
    a_pwm_full_high: assert property (@(posedge clk) disable iff (!nrst)
        (mode != tpw_pkg::TPW_PERIOD && timer_bound_q >= res_max && $stable(mode)
         && $stable(timer_bound_q)) |=> wave_q)
        else $error("pwm output not held high at maximum bound");
    a_pwm_duty_cmp: assert property (@(posedge clk) disable iff (!nrst)
        (mode != tpw_pkg::TPW_PERIOD && timer_bound_q < res_max && $stable(mode)
         && $stable(timer_bound_q) && !wr_bnd && !wr_ctl && !wr_scl)
        |=> wave_q == (count_q <= timer_bound_q))
        else $error("pwm output disagrees with count");
    a_pwm6_wrap: assert property (@(posedge clk) disable iff (!nrst)
        (mode == tpw_pkg::TPW_PWM6 && tick && !wr_cnt && count_q == 8'h3F) |=> count_q == 8'h00)
        else $error("6-bit pwm counter did not wrap at 63");
    a_pwm8_wrap: assert property (@(posedge clk) disable iff (!nrst)
        (mode == tpw_pkg::TPW_PWM8 && tick && !wr_cnt && count_q == 8'hFE) |=> count_q == 8'hFF)
        else $error("8-bit pwm counter wrapped early");
    a_gate_low: assert property (@(posedge clk) disable iff (!nrst)
        (COMPARATOR_GATING_OPTION && cmp_result) |-> !wave_out)
        else $error("output not suppressed by comparator");
    a_pin_route: assert property (@(posedge clk) disable iff (!nrst)
        (pin_sel == tpw_pkg::PIN_B) |-> (output_pin_b_oe && output_pin_b == wave_out
         && !output_pin_a_oe && !output_pin_c_oe))
        else $error("pin routing wrong");
    // other routes must release their pins while one is selected
    a_pin_route_a: assert property (@(posedge clk) disable iff (!nrst)
        (pin_sel == tpw_pkg::PIN_A) |-> (output_pin_a_oe && output_pin_a == wave_out
         && !output_pin_b_oe && !output_pin_c_oe))
        else $error("pin a routing wrong");
    a_pin_route_c: assert property (@(posedge clk) disable iff (!nrst)
        (pin_sel == tpw_pkg::PIN_C) |-> (output_pin_c_oe && output_pin_c == wave_out
         && !output_pin_a_oe && !output_pin_b_oe))
        else $error("pin c routing wrong");
    a_pin_route_none: assert property (@(posedge clk) disable iff (!nrst)
        (pin_sel == tpw_pkg::PIN_NONE) |-> (!output_pin_a_oe && !output_pin_b_oe
         && !output_pin_c_oe))
        else $error("a pin is driven with routing off");
    // read data stands one cycle only, so a missed strobe reads as zero
    a_rdata_idle: assert property (@(posedge clk) disable iff (!nrst)
        !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data present without a read strobe");

    // the 8-bit wrap is a top-count tick with no software write in the way
    sequence s_pwm8_top;
        mode == tpw_pkg::TPW_PWM8 && tick && !wr_cnt && !wr_ctl && !wr_scl
        && count_q == tpw_pkg::MAX_8BIT;
    endsequence
    sequence s_count_zero;
        count_q == 8'h00;
    endsequence
    a_pwm8_top_wrap: assert property (@(posedge clk) disable iff (!nrst)
        s_pwm8_top |=> s_count_zero)
        else $error("8-bit pwm counter did not wrap at 255");
    a_count_write: assert property (@(posedge clk) disable iff (!nrst)
        wr_cnt |=> count_q == $past(reg_wdata))
        else $error("count register write lost");
    a_stop_source: assert property (@(posedge clk) disable iff (!nrst)
        (timer_control_q[7:4] == tpw_pkg::SRC_STOP) |-> !tick)
        else $error("timer ticked with source stopped");
endmodule

// File: verif/tpw_load.sv
// external load model: counts high samples and rising edges on the routed pin line
`timescale 1ns/1ps
module tpw_load (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // window restart and observed line
    input wire logic clr,
    input wire logic pin,
    // counts over the current window
    output logic [15:0] hi_n,
    output logic [15:0] rise_n
);
    logic prev_q;
    // line is pulled low when no pin drives it; a window of whole periods gives exact counts
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hi_n <= 16'h0000;
            rise_n <= 16'h0000;
            prev_q <= 1'b0;
        end else begin
            prev_q <= pin;
            hi_n <= clr ? 16'h0000 : hi_n + {15'h0000, pin};
            rise_n <= clr ? 16'h0000 : rise_n + {15'h0000, pin & ~prev_q};
        end
    end
endmodule

// File: verif/testbench.sv
// self-checking bench for the timer/pwm block with a pin load model
`timescale 1ns/1ps
module testbench;
    logic clk, nrst, reg_wr, reg_rd, cmp_result, clr, line;
    logic [1:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, d;
    logic [14:0] ext_src_en;
    logic pa, pa_oe, pb, pb_oe, pc, pc_oe, wave_out;
    logic [15:0] hi_n, rise_n;
    int bad_count, tests_run;

    // only one pin is routed at a time, so the load sees whichever drives
    assign line = (pa & pa_oe) | (pb & pb_oe) | (pc & pc_oe);

    tpw_timer #(.COMPARATOR_GATING_OPTION(1'b1)) i_dut (.clk(clk), .nrst(nrst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .ext_src_en(ext_src_en), .cmp_result(cmp_result),
        .output_pin_a(pa), .output_pin_a_oe(pa_oe), .output_pin_b(pb),
        .output_pin_b_oe(pb_oe), .output_pin_c(pc), .output_pin_c_oe(pc_oe),
        .wave_out(wave_out));
    tpw_load i_load (.clk(clk), .nrst(nrst), .clr(clr), .pin(line), .hi_n(hi_n),
        .rise_n(rise_n));

    // clock and an external source enabled every other cycle (source code 2)
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) ext_src_en <= ext_src_en ^ 15'h0002;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, output logic [7:0] v);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic cfg(input logic [7:0] ctl, input logic [7:0] bnd, input logic [7:0] scl);
        wr(tpw_pkg::ADDR_BOUND, bnd);
        wr(tpw_pkg::ADDR_SCALING, scl);
        wr(tpw_pkg::ADDR_CONTROL, ctl);
    endtask
    // settle past the longest old period, then count over 256 cycles
    task automatic meas(input logic [15:0] hi, input logic [15:0] rs);
        repeat (300) @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        repeat (256) @(posedge clk);
        #1;
        check(hi_n, hi);
        check(rise_n, rs);
    endtask
    task automatic t_regs;
        for (int i = 0; i < 4; i++) begin
            rd(i[1:0], d);
            check({8'h00, d}, 16'h0000);
        end
        cfg(8'h04, 8'h00, 8'h00);
        meas(16'h0000, 16'h0000);
        wr(tpw_pkg::ADDR_COUNT, 8'h42);
        wr(tpw_pkg::ADDR_BOUND, 8'hA5);
        rd(tpw_pkg::ADDR_COUNT, d);
        check({8'h00, d}, 16'h0042);
        rd(tpw_pkg::ADDR_BOUND, d);
        check({8'h00, d}, 16'h00A5);
        @(posedge clk);
        #1;
        check({8'h00, reg_rdata}, 16'h0000);
    endtask
    task automatic t_period;
        cfg(8'h14, 8'h03, 8'h00);
        meas(16'h0080, 16'h0020);
        cfg(8'h18, 8'h0F, 8'h00);
        meas(16'h0080, 16'h0008);
        check({13'h0000, pa_oe, pb_oe, pc_oe}, 16'h0002);
        for (int c = 0; c < 4; c++) begin
            cfg(8'h14, 8'h00, {1'b0, c[1:0], 5'h00});
            meas(16'h0080, 16'h0080 >> (2 * c));
        end
        cfg(8'h14, 8'h00, 8'h1F);
        meas(16'h0080, 16'h0004);
        cfg(8'h24, 8'h00, 8'h00);
        meas(16'h0080, 16'h0040);
    endtask
    task automatic t_pwm;
        cfg(8'h16, 8'h09, 8'h00);
        meas(16'h000A, 16'h0001);
        cfg(8'h16, 8'hFF, 8'h00);
        meas(16'h0100, 16'h0000);
        cfg(8'h1E, 8'h1F, 8'h80);
        meas(16'h0080, 16'h0004);
        cfg(8'h1E, 8'h3F, 8'h80);
        meas(16'h0100, 16'h0000);
        cfg(8'h12, 8'hFF, 8'h00);
        meas(16'h0000, 16'h0000);
        check({15'h0000, wave_out}, 16'h0001);
    endtask
    // comparator suppresses the routed waveform and releases it again
    task automatic t_gate;
        cfg(8'h16, 8'hFF, 8'h00);
        cmp_result <= 1'b1;
        meas(16'h0000, 16'h0000);
        @(posedge clk);
        cmp_result <= 1'b0;
        meas(16'h0100, 16'h0000);
    endtask

    task automatic final_report;
        $display("mismatches=%0d comparisons=%0d", bad_count, tests_run);
        if (bad_count == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // watchdog: the run needs about 9k cycles, well below this 25k-cycle limit
    initial begin
        #100000;
        bad_count++;
        final_report();
    end
    // main sequence
    initial begin
        {nrst, reg_wr, reg_rd, cmp_result, clr} = 5'h00;
        reg_addr = 2'h0;
        reg_wdata = 8'h00;
        ext_src_en = 15'h0000;
        bad_count = 0;
        tests_run = 0;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        t_regs();
        t_period();
        t_pwm();
        t_gate();
        final_report();
    end
endmodule
